// ===== design/lbtc_config_regs.sv
// Behaviour
// - Unimplemented upper bits: writes dropped, read zero
// - Bit 2 of 05h selects boost frequency
// - Bits 1..0 of 05h select core voltage
// - 06h bits 2..0: buck/LDO soft-start time
// - 07h bits 2..0: boost soft-start time
// - 08h bits 1..0: start-up reset pulse length
`timescale 1ns/1ps
`include "lbtc_regs.svh"

module lbtc_config_regs
   import lbtc_pkg::*;
#(
   parameter int unsigned ADDR_W          = 8,
   parameter int unsigned SS_STEP_CYCLES  = `LBTC_SS_STEP_CYC,
   parameter int unsigned RST_BASE_CYCLES = `LBTC_RST_BASE_CYC
) (
   // Clock, reset, enable
   input  wire logic              CLK_SYS,
   input  wire logic              RESETN,
   input  wire logic              CE,
   // AXI4-Lite write address
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   // AXI4-Lite write data
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   // AXI4-Lite write response
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   // AXI4-Lite read address
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   // AXI4-Lite read data
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   // Converter settings
   output logic                   BOOST_SWITCH_RATE_SEL,
   output logic [1:0]             CORE_BUCK_VOLTAGE_SEL,
   output logic [2:0]             BUCK_LDO_SOFTSTART_SEL,
   output logic [2:0]             BOOST_SOFTSTART_SEL,
   output logic [1:0]             RESET_PULSE_SEL,
   // Decoded times in clock cycles
   output lbtc_cyc_t              BUCK_LDO_SS_CYCLES,
   output lbtc_cyc_t              BOOST_SS_CYCLES,
   output lbtc_cyc_t              RESET_PULSE_CYCLES
);

   // Write channel state
   logic              aw_held_r;
   logic              w_held_r;
   logic              awready_r;
   logic              wready_r;
   logic              bvalid_r;
   logic [1:0]        bresp_r;
   logic [ADDR_W-1:0] waddr_r;
   logic [7:0]        wdata_r;
   logic              wlane0_r;
   // Read channel state
   logic              arready_r;
   logic              rvalid_r;
   logic [31:0]       rdata_r;
   logic [1:0]        rresp_r;
   // Handshake terms
   logic              aw_take;
   logic              w_take;
   logic              do_write;
   logic              ar_take;
   logic [7:0]        widx;
   logic              wmapped;
   // Field write enables and stored values
   logic              we_misc;
   logic              we_buck;
   logic              we_boost;
   logic              we_rst;
   logic              boost_switch_rate_sel_q;
   logic [1:0]        core_v_q;
   logic [2:0]        buck_ss_q;
   logic [2:0]        boost_ss_q;
   logic [1:0]        rst_len_q;
   // Decoded times
   lbtc_cyc_t         buck_cyc_r;
   lbtc_cyc_t         boost_cyc_r;
   lbtc_cyc_t         rst_cyc_r;

   // Byte address is four times the index
   function automatic logic [7:0] idx_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] s;
      s      = a >> 2;
      idx_of = s[7:0];
   endfunction : idx_of

   // Read word assembly
   // Upper bits zero
   function automatic logic [32:0] read_word(input logic [ADDR_W-1:0] a, input logic f,
                                             input logic [1:0] v, input logic [2:0] s1,
                                             input logic [2:0] s2, input logic [1:0] r);
      logic [31:0] w;
      logic        hit;
      w   = 32'h0;
      hit = 1'b1;
      case (idx_of(a))
         `LBTC_IDX_MISC: begin
            w[`LBTC_BOOST_SWITCH_RATE_SEL_BIT]                    = f;
            w[`LBTC_CORE_V_MSB:`LBTC_CORE_V_LSB] = v;
         end
         `LBTC_IDX_BUCK_SS:   w[`LBTC_BUCK_SS_MSB:`LBTC_BUCK_SS_LSB]     = s1;
         `LBTC_IDX_BOOST_SS:  w[`LBTC_BOOST_SS_MSB:`LBTC_BOOST_SS_LSB]   = s2;
         `LBTC_IDX_RST_PULSE: w[`LBTC_RST_PULSE_MSB:`LBTC_RST_PULSE_LSB] = r;
         default:             hit = 1'b0;
      endcase
      read_word = {hit, w};
   endfunction : read_word

   // Handshakes; a write runs once both halves are held
   assign aw_take  = AWVALID && awready_r;
   assign w_take   = WVALID && wready_r;
   assign do_write = aw_held_r && w_held_r && !bvalid_r;
   assign ar_take  = ARVALID && arready_r;
   assign widx     = idx_of(waddr_r);
   assign wmapped  = (widx == `LBTC_IDX_MISC) || (widx == `LBTC_IDX_BUCK_SS) ||
                     (widx == `LBTC_IDX_BOOST_SS) || (widx == `LBTC_IDX_RST_PULSE);

   // Write address capture; ready drops while one is held
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         aw_held_r <= 1'b0;
         awready_r <= 1'b0;
         waddr_r   <= '0;
      end else if (CE) begin
         if (aw_take) begin
            aw_held_r <= 1'b1;
            awready_r <= 1'b0;
            waddr_r   <= AWADDR;
         end else if (do_write) begin
            aw_held_r <= 1'b0;
            awready_r <= 1'b1;
         end else begin
            awready_r <= !aw_held_r;
         end
      end
   end

   // Write data capture; only the low byte can carry fields
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         w_held_r <= 1'b0;
         wready_r <= 1'b0;
         wdata_r  <= 8'h00;
         wlane0_r <= 1'b0;
      end else if (CE) begin
         if (w_take) begin
            w_held_r <= 1'b1;
            wready_r <= 1'b0;
            wdata_r  <= WDATA[7:0];
            wlane0_r <= WSTRB[0];
         end else if (do_write) begin
            w_held_r <= 1'b0;
            wready_r <= 1'b1;
         end else begin
            wready_r <= !w_held_r;
         end
      end
   end

   // Write response; unmapped addresses answer SLVERR
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         bvalid_r <= 1'b0;
         bresp_r  <= LBTC_RESP_OKAY;
      end else if (CE) begin
         if (do_write) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wmapped ? LBTC_RESP_OKAY : LBTC_RESP_SLVERR;
         end else if (bvalid_r && BREADY) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Field write enables; byte lane 0 must be strobed
   assign we_misc  = do_write && wlane0_r && (widx == `LBTC_IDX_MISC);
   assign we_buck  = do_write && wlane0_r && (widx == `LBTC_IDX_BUCK_SS);
   assign we_boost = do_write && wlane0_r && (widx == `LBTC_IDX_BOOST_SS);
   assign we_rst   = do_write && wlane0_r && (widx == `LBTC_IDX_RST_PULSE);

   lbtc_field #(.W(1), .RST(`LBTC_BOOST_SWITCH_RATE_SEL_RST)) u_boost_switch_rate_sel (.clk(CLK_SYS), .rstn(RESETN), .ce(CE),
      .we(we_misc), .d(wdata_r[`LBTC_BOOST_SWITCH_RATE_SEL_BIT]), .q(boost_switch_rate_sel_q));

   lbtc_field #(.W(2), .RST(`LBTC_CORE_V_RST)) u_core_v (.clk(CLK_SYS), .rstn(RESETN), .ce(CE),
      .we(we_misc), .d(wdata_r[`LBTC_CORE_V_MSB:`LBTC_CORE_V_LSB]), .q(core_v_q));

   lbtc_field #(.W(3), .RST(`LBTC_BUCK_SS_RST)) u_buck_ss (.clk(CLK_SYS), .rstn(RESETN), .ce(CE),
      .we(we_buck), .d(wdata_r[`LBTC_BUCK_SS_MSB:`LBTC_BUCK_SS_LSB]), .q(buck_ss_q));

   lbtc_field #(.W(3), .RST(`LBTC_BOOST_SS_RST)) u_boost_ss (.clk(CLK_SYS), .rstn(RESETN), .ce(CE),
      .we(we_boost), .d(wdata_r[`LBTC_BOOST_SS_MSB:`LBTC_BOOST_SS_LSB]), .q(boost_ss_q));

   lbtc_field #(.W(2), .RST(`LBTC_RST_PULSE_RST)) u_rst_len (.clk(CLK_SYS), .rstn(RESETN), .ce(CE),
      .we(we_rst), .d(wdata_r[`LBTC_RST_PULSE_MSB:`LBTC_RST_PULSE_LSB]), .q(rst_len_q));

   // Read channel; one read in flight, address taken only when idle
   // Read returns stored fields
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rdata_r   <= 32'h0;
         rresp_r   <= LBTC_RESP_OKAY;
      end else if (CE) begin
         if (ar_take) begin
            logic [32:0] rw;
            rw        = read_word(ARADDR, boost_switch_rate_sel_q, core_v_q, buck_ss_q, boost_ss_q, rst_len_q);
            arready_r <= 1'b0;
            rvalid_r  <= 1'b1;
            rdata_r   <= rw[31:0];
            rresp_r   <= rw[32] ? LBTC_RESP_OKAY : LBTC_RESP_SLVERR;
         end else if (rvalid_r && RREADY) begin
            rvalid_r  <= 1'b0;
            arready_r <= 1'b1;
         end else begin
            arready_r <= !rvalid_r;
         end
      end
   end

   // Decoded times, registered so the outputs come from flops
   // Codes are small so the products never leave 24 bits
   // Buck/LDO time (code+1) steps
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         buck_cyc_r <= 24'h0;
      end else if (CE) begin
         buck_cyc_r <= 24'((24'(buck_ss_q) + 24'h1) * 24'(SS_STEP_CYCLES));
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         boost_cyc_r <= 24'h0;
      end else if (CE) begin
         boost_cyc_r <= 24'((24'(boost_ss_q) + 24'(`LBTC_BOOST_SS_BASE)) * 24'(SS_STEP_CYCLES));
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) begin
         rst_cyc_r <= 24'h0;
      end else if (CE) begin
         rst_cyc_r <= 24'(RST_BASE_CYCLES) << rst_len_q;
      end
   end

   // Port drive
   // Settings driven continuously
   assign AWREADY                = awready_r;
   assign WREADY                 = wready_r;
   assign BVALID                 = bvalid_r;
   assign BRESP                  = bresp_r;
   assign ARREADY                = arready_r;
   assign RVALID                 = rvalid_r;
   assign RDATA                  = rdata_r;
   assign RRESP                  = rresp_r;
   assign BOOST_SWITCH_RATE_SEL  = boost_switch_rate_sel_q;
   assign CORE_BUCK_VOLTAGE_SEL  = core_v_q;
   assign BUCK_LDO_SOFTSTART_SEL = buck_ss_q;
   assign BOOST_SOFTSTART_SEL    = boost_ss_q;
   assign RESET_PULSE_SEL        = rst_len_q;
   assign BUCK_LDO_SS_CYCLES     = buck_cyc_r;
   assign BOOST_SS_CYCLES        = boost_cyc_r;
   assign RESET_PULSE_CYCLES     = rst_cyc_r;

endmodule : lbtc_config_regs

// ===== design/lbtc_field.sv
`timescale 1ns/1ps
// One implemented register field: holds the last written value
module lbtc_field #(
   parameter int unsigned W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // Clock and control
   input  wire logic         clk,
   input  wire logic         rstn,
   input  wire logic         ce,
   // Write port
   input  wire logic         we,
   input  wire logic [W-1:0] d,
   // Stored value
   output logic      [W-1:0] q
);

   // Store on write, freeze while ce is low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= RST;
      end else if (ce && we) begin
         q <= d;
      end
   end

endmodule : lbtc_field

// ===== design/lbtc_pkg.sv
package lbtc_pkg;

   // AXI response codes used by the slave
   typedef enum logic [1:0] {
      LBTC_RESP_OKAY   = 2'h0,
      LBTC_RESP_SLVERR = 2'h2
   } lbtc_resp_t;

   // Width of the decoded cycle counts
   typedef logic [23:0] lbtc_cyc_t;

endpackage : lbtc_pkg

// ===== design/lbtc_regs.svh
`ifndef LBTC_REGS_SVH
`define LBTC_REGS_SVH

// Register indices; the byte address is four times the index
`define LBTC_IDX_MISC        8'h05
`define LBTC_IDX_BUCK_SS     8'h06
`define LBTC_IDX_BOOST_SS    8'h07
`define LBTC_IDX_RST_PULSE   8'h08

// Field positions
`define LBTC_BOOST_SWITCH_RATE_SEL_BIT        2
`define LBTC_CORE_V_MSB      1
`define LBTC_CORE_V_LSB      0
`define LBTC_BUCK_SS_MSB     2
`define LBTC_BUCK_SS_LSB     0
`define LBTC_BOOST_SS_MSB    2
`define LBTC_BOOST_SS_LSB    0
`define LBTC_RST_PULSE_MSB   1
`define LBTC_RST_PULSE_LSB   0

// Reset values of the fields
`define LBTC_BOOST_SWITCH_RATE_SEL_RST        1'h0
`define LBTC_CORE_V_RST      2'h0
`define LBTC_BUCK_SS_RST     3'h0
`define LBTC_BOOST_SS_RST    3'h0
`define LBTC_RST_PULSE_RST   2'h0

// Timing: clock rate and printed times in microseconds
`define LBTC_CLK_MHZ         100
`define LBTC_SS_STEP_US      500
`define LBTC_BOOST_SS_BASE   8
`define LBTC_RST_BASE_US     2000
`define LBTC_SS_STEP_CYC     (`LBTC_SS_STEP_US * `LBTC_CLK_MHZ)
`define LBTC_RST_BASE_CYC    (`LBTC_RST_BASE_US * `LBTC_CLK_MHZ)

`endif

// ===== testbench/lbtc_config_regs_asserts.sv
`timescale 1ns/1ps
module lbtc_config_regs_asserts
   import lbtc_pkg::*;
#(
   parameter int unsigned ADDR_W          = 8,
   parameter int unsigned SS_STEP_CYCLES  = 5,
   parameter int unsigned RST_BASE_CYCLES = 20
) (
   // Clock and control
   input wire logic              CLK_SYS,
   input wire logic              RESETN,
   input wire logic              CE,
   // Bus
   input wire logic              AWVALID,
   input wire logic              AWREADY,
   input wire logic              WVALID,
   input wire logic              WREADY,
   input wire logic              BVALID,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic              ARVALID,
   input wire logic              ARREADY,
   input wire logic [31:0]       RDATA,
   input wire logic [1:0]        RRESP,
   input wire logic              RVALID,
   // Settings
   input wire logic              BOOST_SWITCH_RATE_SEL,
   input wire logic [1:0]        CORE_BUCK_VOLTAGE_SEL,
   input wire logic [2:0]        BUCK_LDO_SOFTSTART_SEL,
   input wire logic [2:0]        BOOST_SOFTSTART_SEL,
   input wire logic [1:0]        RESET_PULSE_SEL,
   input wire lbtc_cyc_t         BUCK_LDO_SS_CYCLES,
   input wire lbtc_cyc_t         BOOST_SS_CYCLES,
   input wire lbtc_cyc_t         RESET_PULSE_CYCLES
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);
   logic [ADDR_W-1:0] ar_q;
   logic [31:0]       keep_m;
   logic [10:0]       sel_all;
   // Address of the read in flight, for its mask
   always_ff @(posedge CLK_SYS or negedge RESETN) begin
      if (!RESETN) ar_q <= '0;
      else if (CE && ARVALID && ARREADY) ar_q <= ARADDR;
   end
   // Pulse register has two bits, the others three
   assign keep_m = (ar_q[7:2] == 6'h08) ? 32'h3 : 32'h7;
   assign sel_all = {BOOST_SWITCH_RATE_SEL, CORE_BUCK_VOLTAGE_SEL, BUCK_LDO_SOFTSTART_SEL,
                     BOOST_SOFTSTART_SEL, RESET_PULSE_SEL};
   a_upper_bits_zero: assert property (RVALID |-> (RDATA & ~keep_m) == 32'h0)
      else $error("read data beyond field");
   a_boost_switch_rate_sel_volt_read: assert property ($rose(RVALID) && ar_q[7:2] == 6'h05 && RRESP == 2'h0 &&
      $stable(sel_all) |-> RDATA[2:0] == {BOOST_SWITCH_RATE_SEL, CORE_BUCK_VOLTAGE_SEL})
      else $error("rate and voltage read mismatch");
   a_buck_ss_count: assert property (CE |=>
      BUCK_LDO_SS_CYCLES == ($past(BUCK_LDO_SOFTSTART_SEL) + 1) * SS_STEP_CYCLES)
      else $error("buck soft start count wrong");
   a_boost_ss_count: assert property (CE |=>
      BOOST_SS_CYCLES == ($past(BOOST_SOFTSTART_SEL) + 8) * SS_STEP_CYCLES)
      else $error("boost soft start count wrong");
   a_pulse_len_count: assert property (CE |=>
      RESET_PULSE_CYCLES == (RST_BASE_CYCLES << $past(RESET_PULSE_SEL)))
      else $error("reset pulse count wrong");
   a_fields_hold: assert property (!$rose(BVALID) |-> $stable(sel_all))
      else $error("setting changed without write");
   a_read_answer: assert property (CE && ARVALID && ARREADY |=> RVALID)
      else $error("read not answered");
   a_write_answer: assert property (CE && AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
      else $error("write not answered");
endmodule : lbtc_config_regs_asserts

bind lbtc_config_regs lbtc_config_regs_asserts #(.ADDR_W(ADDR_W), .SS_STEP_CYCLES(SS_STEP_CYCLES),
   .RST_BASE_CYCLES(RST_BASE_CYCLES)) u_chk (.CLK_SYS, .RESETN, .CE, .AWVALID, .AWREADY, .WVALID,
   .WREADY, .BVALID, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .BOOST_SWITCH_RATE_SEL,
   .CORE_BUCK_VOLTAGE_SEL, .BUCK_LDO_SOFTSTART_SEL, .BOOST_SOFTSTART_SEL, .RESET_PULSE_SEL,
   .BUCK_LDO_SS_CYCLES, .BOOST_SS_CYCLES, .RESET_PULSE_CYCLES);

// ===== testbench/lbtc_config_regs_tb_top.sv
`timescale 1ns/1ps
`include "lbtc_regs.svh"
module lbtc_config_regs_tb_top
   import lbtc_pkg::*;
;
   localparam int SS = 5;
   localparam int RB = 20;
   logic       CLK_SYS, RESETN, CE, AWVALID, WVALID, BREADY, ARVALID, RREADY;
   logic       AWREADY, WREADY, BVALID, ARREADY, RVALID, BOOST_SWITCH_RATE_SEL;
   logic [7:0] AWADDR, ARADDR;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, CORE_BUCK_VOLTAGE_SEL, RESET_PULSE_SEL;
   logic [2:0] BUCK_LDO_SOFTSTART_SEL, BOOST_SOFTSTART_SEL;
   lbtc_cyc_t  BUCK_LDO_SS_CYCLES, BOOST_SS_CYCLES, RESET_PULSE_CYCLES;
   int         miscompares, n_checks, i, c;
   logic [33:0] rq[$];
   logic [1:0] bq[$];
   logic [7:0] mdl[4];
   logic [7:0] msk[4] = '{8'h7, 8'h7, 8'h7, 8'h3};
   lbtc_config_regs #(.SS_STEP_CYCLES(SS), .RST_BASE_CYCLES(RB)) u_dut (.CLK_SYS, .RESETN, .CE,
      .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY,
      .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .BOOST_SWITCH_RATE_SEL,
      .CORE_BUCK_VOLTAGE_SEL, .BUCK_LDO_SOFTSTART_SEL, .BOOST_SOFTSTART_SEL, .RESET_PULSE_SEL,
      .BUCK_LDO_SS_CYCLES, .BOOST_SS_CYCLES, .RESET_PULSE_CYCLES);
   // 100 MHz clock
   initial begin
      CLK_SYS = 0;
      forever #5 CLK_SYS = ~CLK_SYS;
   end
   task chk(input logic [35:0] s, input logic [35:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("unexpected at %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask : chk
   task summarize;
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : summarize
   // Byte address is four times the register index
   function logic [7:0] ad(input int n);
      return 8'(4 * (`LBTC_IDX_MISC + n));
   endfunction : ad
   // Write; address and data offered together after gap idle cycles
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input int gap, input logic [1:0] er);
      int k;
      bit ta;
      bit tw;
      ta = 0;
      tw = 0;
      bq.push_back(er);
      repeat (gap + 1) @(posedge CLK_SYS);
      AWADDR  <= a;
      WDATA   <= d;
      WSTRB   <= s;
      AWVALID <= 1;
      WVALID  <= 1;
      BREADY  <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge CLK_SYS);
         if (AWVALID && AWREADY) ta = 1;
         if (WVALID && WREADY) tw = 1;
         AWVALID <= !ta;
         WVALID  <= !tw;
         if (BVALID && BREADY) break;
      end
      BREADY <= 0;
      if (k == 50) begin
         miscompares++;
         summarize;
      end
   endtask : wr
   task wreg(input int n, input logic [31:0] d, input logic [3:0] s, input int gap);
      wr(ad(n), d, s, gap, LBTC_RESP_OKAY);
      if (s[0]) mdl[n] = d[7:0] & msk[n];
   endtask : wreg
   // Read; address released once taken, ready held until the answer
   task rd(input logic [7:0] a, input logic [33:0] e);
      int k;
      rq.push_back(e);
      @(posedge CLK_SYS);
      ARADDR  <= a;
      ARVALID <= 1;
      RREADY  <= 1;
      for (k = 0; k < 50; k++) begin
         @(posedge CLK_SYS);
         if (ARVALID && ARREADY) ARVALID <= 0;
         if (RVALID && RREADY) break;
      end
      RREADY <= 0;
      if (k == 50) begin
         miscompares++;
         summarize;
      end
   endtask : rd
   task rdm(input int n);
      rd(ad(n), {2'h0, 24'h0, mdl[n]});
   endtask : rdm
   // Counts trail the codes by one cycle
   task outs;
      repeat (2) @(posedge CLK_SYS);
      #1;
      chk(BOOST_SWITCH_RATE_SEL, mdl[0][2]);
      chk(CORE_BUCK_VOLTAGE_SEL, mdl[0][1:0]);
      chk(BUCK_LDO_SOFTSTART_SEL, mdl[1][2:0]);
      chk(BUCK_LDO_SS_CYCLES, (mdl[1] + 1) * SS);
      chk(BOOST_SOFTSTART_SEL, mdl[2][2:0]);
      chk(BOOST_SS_CYCLES, (mdl[2] + 8) * SS);
      chk(RESET_PULSE_SEL, mdl[3][1:0]);
      chk(RESET_PULSE_CYCLES, RB << mdl[3]);
   endtask : outs
   // Watcher: oldest note against each answer
   always @(posedge CLK_SYS) begin
      if (RESETN && RVALID && RREADY) begin
         if (rq.size() == 0) chk(36'h1, 36'h0);
         else chk({RRESP, RDATA}, rq.pop_front());
      end
      if (RESETN && BVALID && BREADY) begin
         if (bq.size() == 0) chk(36'h1, 36'h0);
         else chk(BRESP, bq.pop_front());
      end
   end
   initial begin
      RESETN = 0;
      CE = 0;
      AWVALID = 0;
      WVALID = 0;
      BREADY = 0;
      ARVALID = 0;
      RREADY = 0;
      AWADDR = 0;
      ARADDR = 0;
      WDATA = 0;
      WSTRB = 0;
      miscompares = 0;
      n_checks = 0;
      mdl = '{default: 0};
      void'($urandom(28920));
      repeat (8) @(posedge CLK_SYS);
      RESETN <= 1;
      CE <= 1;
      outs;
      for (i = 0; i < 4; i++) rdm(i);
      // Every code, random upper bits, varied gaps
      for (i = 0; i < 4; i++) begin
         for (c = 0; c < 8; c++) begin
            wreg(i, ($urandom & 32'hfffffff8) | c, 4'hf, c % 3);
            rdm(i);
            outs;
         end
      end
      // Unmapped place and a write without lane 0
      wr(ad(4), 32'h7, 4'hf, 0, LBTC_RESP_SLVERR);
      rd(ad(4), {LBTC_RESP_SLVERR, 32'h0});
      wreg(1, 32'h2, 4'he, 0);
      rdm(1);
      outs;
      // Two writes, the second after one idle cycle, then a clock-enable stall
      wreg(0, $urandom, 4'h1, 0);
      wreg(3, $urandom, 4'h1, 1);
      @(posedge CLK_SYS);
      CE <= 0;
      repeat (4) @(posedge CLK_SYS);
      CE <= 1;
      outs;
      // Reset in mid-run clears every field
      @(posedge CLK_SYS);
      RESETN <= 0;
      repeat (2) @(posedge CLK_SYS);
      RESETN <= 1;
      mdl = '{default: 0};
      outs;
      for (i = 0; i < 4; i++) rdm(i);
      summarize;
   end
endmodule : lbtc_config_regs_tb_top
